// *** cntfc_host.sv ***
// Host-side controller that drives the transceiver transmit and mode pins
// Overview of operation
// R1 - Dominant is logic low on transmit and receive pins.
// R2 - Recessive is logic high on transmit and receive pins.
// R3 - Transceiver resolves bus dominant if any node drives dominant.
// R4 - Transceiver supervises dominant timeout only in normal mode.
// R5 - Transceiver starts timeout timer on transmit falling edge.
// R6 - No rising edge within 1.2 ms disables the transceiver driver.
// R7 - Transceiver re-enables driver once transmit returns recessive.
// R8 - Receiver keeps following the bus during a timeout fault.
// R9 - Host never holds transmit dominant over 11 successive bit times.
// R10 - Over-temperature turns driver off and blocks transmit path.
// R11 - Thermal fault clears only below threshold, with hysteresis.
// R12 - Receive path stays working during thermal fault.
// R13 - Undervoltage on either supply forces protected state.
// R14 - Protected state floats bus and receive output.
// R15 - Receive output driven only with the I/O supply present.
// R16 - Host drives the silent-select pin to pick silent or normal.
// R17 - Silent high disables driver; low enables driver and receiver.
// R18 - Floating silent-select means silent, floating transmit means recessive.
// R19 - Floating transmit is recessive, no blocking or timeout.
// R20 - After undervoltage clears and mode time passes, normal resumes.
// R21 - Timeout is measured by a counter reset on transmit rising edge.
`timescale 1ns/100ps
`default_nettype none
module cntfc_host (
  input wire logic clk_sys,
  input wire logic rst,
  // User side
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_bit,
  input wire logic [23:0] bit_cycles,
  input wire logic silent_req,
  output logic rx_bit,
  output logic rx_strobe,
  output logic dom_limit_hit,
  output logic mode_ready,
  // Transceiver pins
  output logic txd_pin,
  output logic silent_pin,
  input wire logic rxd_pin
);
  typedef enum logic [1:0] {CNTFC_IDLE, CNTFC_BIT} cntfc_state_e;
  cntfc_state_e st_r, st_nxt;
  logic [23:0] bcnt_r, bcnt_nxt;
  logic [3:0] dom_r, dom_nxt;
  logic txd_r, txd_nxt, hit_r, hit_nxt;
  logic [23:0] mcnt_r, mcnt_nxt;
  logic sil_r, sil_nxt, mrdy_r, mrdy_nxt;
  logic rx_r, rx_nxt, rxs_r, rxs_nxt;
  logic f_valid, f_ready, f_data, pop;
  cntfc_fifo #(.W(cntfc_pkg::FIFO_W), .D(cntfc_pkg::FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(f_ready),
    .in_data(tx_bit),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );
  // Bit sequencer with dominant run limit
  always_comb begin
    st_nxt = st_r;
    bcnt_nxt = bcnt_r;
    dom_nxt = dom_r;
    txd_nxt = txd_r;
    hit_nxt = 1'b0;
    pop = 1'b0;
    case (st_r)
      CNTFC_IDLE: begin
        txd_nxt = cntfc_pkg::LVL_RECESSIVE; // see R2
        // Transmit only once the transceiver has settled in normal mode
        if (f_valid && mrdy_r && !sil_r) begin // see R20
          pop = 1'b1;
          bcnt_nxt = (bit_cycles == 24'h000000) ? cntfc_pkg::BIT_CYC_RST : bit_cycles;
          st_nxt = CNTFC_BIT;
          if (f_data == cntfc_pkg::LVL_DOMINANT) begin // see R1
            if (dom_r == 4'(cntfc_pkg::MAX_DOM_BITS)) begin // see R9
              // Forced recessive breaks the run rather than trip the timeout
              txd_nxt = cntfc_pkg::LVL_RECESSIVE;
              dom_nxt = 4'h0;
              hit_nxt = 1'b1;
            end else begin
              txd_nxt = cntfc_pkg::LVL_DOMINANT;
              dom_nxt = dom_r + 4'h1;
            end
          end else begin
            txd_nxt = cntfc_pkg::LVL_RECESSIVE;
            dom_nxt = 4'h0;
          end
        end else begin
          dom_nxt = 4'h0;
        end
      end
      CNTFC_BIT: begin
        bcnt_nxt = bcnt_r - 24'h000001;
        if (bcnt_r <= 24'h000001) begin
          // Back to back bits keep the line at its level
          if (f_valid && mrdy_r && !sil_r) begin
            pop = 1'b1;
            bcnt_nxt = (bit_cycles == 24'h000000) ? cntfc_pkg::BIT_CYC_RST : bit_cycles;
            if (f_data == cntfc_pkg::LVL_DOMINANT && dom_r != 4'(cntfc_pkg::MAX_DOM_BITS)) begin
              txd_nxt = cntfc_pkg::LVL_DOMINANT;
              dom_nxt = dom_r + 4'h1;
            end else begin
              hit_nxt = (f_data == cntfc_pkg::LVL_DOMINANT); // see R9
              txd_nxt = cntfc_pkg::LVL_RECESSIVE;
              dom_nxt = 4'h0;
            end
          end else begin
            st_nxt = CNTFC_IDLE;
            txd_nxt = cntfc_pkg::LVL_RECESSIVE;
            dom_nxt = 4'h0;
          end
        end
      end
      default: begin
        st_nxt = CNTFC_IDLE;
        txd_nxt = cntfc_pkg::LVL_RECESSIVE;
      end
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= CNTFC_IDLE;
      bcnt_r <= 24'h000000;
      dom_r <= 4'h0;
      txd_r <= 1'b1;
      hit_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bcnt_r <= bcnt_nxt;
      dom_r <= dom_nxt;
      txd_r <= txd_nxt;
      hit_r <= hit_nxt;
    end
  end
  // Mode pin and settle timer
  always_comb begin
    sil_nxt = silent_req ? cntfc_pkg::SILENT_ON : cntfc_pkg::SILENT_OFF; // see R16
    mcnt_nxt = mcnt_r;
    mrdy_nxt = mrdy_r;
    if (sil_nxt != sil_r) begin // see R17
      mcnt_nxt = 24'(cntfc_pkg::MODE_CYC);
      mrdy_nxt = 1'b0;
    end else if (mcnt_r != 24'h000000) begin
      mcnt_nxt = mcnt_r - 24'h000001;
    end else begin
      mrdy_nxt = 1'b1;
    end
  end
  // Receive sampling; an edge marks a change seen on the bus
  always_comb begin
    rx_nxt = rxd_pin;
    rxs_nxt = (rxd_pin != rx_r);
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Silent at reset, as a floating select pin would give
      sil_r <= 1'b1; // see R18
      mcnt_r <= 24'(cntfc_pkg::MODE_CYC);
      mrdy_r <= 1'b0;
      rx_r <= 1'b1;
      rxs_r <= 1'b0;
    end else begin
      sil_r <= sil_nxt;
      mcnt_r <= mcnt_nxt;
      mrdy_r <= mrdy_nxt;
      rx_r <= rx_nxt;
      rxs_r <= rxs_nxt;
    end
  end
  assign tx_ready = f_ready;
  assign txd_pin = txd_r;
  assign silent_pin = sil_r;
  assign rx_bit = rx_r;
  assign rx_strobe = rxs_r;
  assign dom_limit_hit = hit_r;
  assign mode_ready = mrdy_r;
endmodule
`default_nettype wire

// *** cntfc_pkg.sv ***
// Package of constants for the CAN transceiver host-side controller
package cntfc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // Longest dominant run the host allows on the transmit pin, in bit times
  localparam int unsigned MAX_DOM_BITS = 11;
  // Dominant timeout minimum, in microseconds (1.2 ms)
  localparam int unsigned DOM_TIMEOUT_US = 1200;
  localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * CLK_MHZ;
  // Mode change time, in microseconds
  localparam int unsigned MODE_US = 20;
  localparam int unsigned MODE_CYC = MODE_US * CLK_MHZ;
  // Lowest usable rate in bits per second (9.2 kbps)
  localparam int unsigned MIN_RATE_BPS = 9200;
  localparam int unsigned FIFO_W = 1;
  localparam int unsigned FIFO_D = 16;
  localparam int unsigned CNT_W = 24;
  localparam logic LVL_DOMINANT = 1'b0;
  localparam logic LVL_RECESSIVE = 1'b1;
  localparam logic SILENT_ON = 1'b1;
  localparam logic SILENT_OFF = 1'b0;
  localparam logic [CNT_W-1:0] BIT_CYC_RST = 24'h0003E8;
endpackage

// *** cntfc_fifo.sv ***
// Bit FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module cntfc_fifo #(
  parameter int unsigned W = 1,
  parameter int unsigned D = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic wr, rd;
  // Ready is registered so that the top-level ready output comes from a flip-flop
  logic in_ready_r;
  always_comb begin
    wr = in_valid && (cnt_r != (AW+1)'(D));
    rd = out_ready && (cnt_r != '0);
    wp_nxt = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (wr && !rd) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (rd && !wr) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt != (AW+1)'(D));
    end
  end
  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem_r[wp_r] <= in_data;
    end
  end
  assign in_ready = in_ready_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
endmodule
`default_nettype wire

// *** cntfc_host_chk.sv ***
// Port checker for the host controller
`timescale 1ns/100ps
`default_nettype none
module cntfc_host_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic silent_req,
  input wire logic [23:0] bit_cycles,
  input wire logic rx_bit,
  input wire logic rx_strobe,
  input wire logic dom_limit_hit,
  input wire logic mode_ready,
  input wire logic txd_pin,
  input wire logic silent_pin,
  input wire logic rxd_pin
);
  logic [27:0] run_r;
  logic [27:0] run_nxt;
  // Counts low cycles on the pin; a counter avoids a huge repetition
  always_comb begin
    run_nxt = txd_pin ? 28'h0000000 : run_r + 28'h0000001;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_r <= 28'h0000000;
    end else begin
      run_r <= run_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_rx_mirror: assert property (rxd_pin != rx_bit |=> rx_strobe && rx_bit == $past(rxd_pin))
    else $error("rx_bit missed a change");
  chk_dom_run: assert property (run_r <= cntfc_pkg::MAX_DOM_BITS * (bit_cycles == 24'h000000 ? cntfc_pkg::BIT_CYC_RST : bit_cycles))
    else $error("dominant run too long");
  chk_hit_rec: assert property (dom_limit_hit |-> ##[0:2] txd_pin)
    else $error("limit hit without recessive");
  chk_silent_follow: assert property (1'b1 |=> silent_pin == $past(silent_req))
    else $error("silent_pin lags request");
  chk_mode_drop: assert property ($changed(silent_pin) |-> !mode_ready)
    else $error("mode_ready kept on change");
  chk_send_normal: assert property ($fell(txd_pin) |-> $past(mode_ready) && !$past(silent_pin))
    else $error("sent while not in normal mode");
endmodule
bind cntfc_host cntfc_host_chk i_chk (.clk_sys, .rst, .silent_req, .bit_cycles, .rx_bit,
  .rx_strobe, .dom_limit_hit, .mode_ready, .txd_pin, .silent_pin, .rxd_pin);
`default_nettype wire

// *** cntfc_xcvr_model.sv ***
// Behavioural transceiver model facing the host controller
`timescale 1ns/100ps
`default_nettype none
module cntfc_xcvr_model #(parameter int TO_CYC = 300) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic txd_pin,
  input wire logic silent_pin,
  input wire logic hot,
  input wire logic other_dom,
  input wire logic uv,
  output wire logic rxd_pin
);
  int cnt_r;
  logic dto_r;
  logic drv;
  // Timer idles unless driving dominant in normal mode; open pin counts as recessive
  always @(posedge clk_sys or posedge rst) begin
    if (rst || silent_pin !== 1'b0 || txd_pin !== 1'b0) begin
      cnt_r <= 0;
      dto_r <= 1'b0;
    end else if (cnt_r == TO_CYC) begin
      dto_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // Undervoltage releases the bus and floats the receive pin
  assign drv = silent_pin === 1'b0 && txd_pin === 1'b0 && !dto_r && !hot && !uv;
  assign rxd_pin = uv ? 1'bz : !(drv || other_dom);
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench for the host controller with a transceiver model
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0, rst = 1'b1, tx_valid = 1'b0, tx_bit = 1'b1, silent_req = 1'b1;
  logic hot = 1'b0, other_dom = 1'b0, uv = 1'b0;
  logic [23:0] bit_cycles = 24'h000008;
  logic tx_ready, rx_bit, rx_strobe, dom_limit_hit, mode_ready, txd_pin, silent_pin;
  // Receive pin has a pull-up so a floated pin reads recessive
  tri1 rxd_pin;
  integer miscompares = 0, cmp_count = 0, hits = 0, strobes = 0, seed = 32'h88922729, i, r;
  cntfc_host i_dut (.clk_sys, .rst, .tx_valid, .tx_ready, .tx_bit, .bit_cycles,
    .silent_req, .rx_bit, .rx_strobe, .dom_limit_hit, .mode_ready, .txd_pin, .silent_pin,
    .rxd_pin);
  cntfc_xcvr_model #(.TO_CYC(300)) i_xcvr (.clk_sys, .rst, .txd_pin, .silent_pin, .hot,
    .other_dom, .uv, .rxd_pin);
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (!rst && dom_limit_hit === 1'b1) hits <= hits + 1;
    if (!rst && rx_strobe === 1'b1) strobes <= strobes + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic one_hit(input int run);
    return (run / 12) == 1;
  endfunction
  task automatic compare(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  // Holds the offer until ready is seen at an edge; the caller drops valid after a run
  task automatic push(input logic b);
    tx_valid = 1'b1;
    tx_bit = b;
    while (tx_ready !== 1'b1) begin
      tick(1);
    end
    tick(1);
  endtask
  task automatic close_out;
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
  initial begin
    tick(2);
    rst = 1'b0;
    for (i = 0; i < 16; i++) push(1'b0);
    tx_valid = 1'b0;
    compare(tx_ready, 1'b0);
    tick(50);
    compare(txd_pin, 1'b1);
    compare(mode_ready, 1'b0);
    silent_req = 1'b0;
    tick(1);
    compare(silent_pin, 1'b0);
    compare(mode_ready, 1'b0);
    for (i = 0; i < 5000 && mode_ready !== 1'b1; i++) tick(1);
    compare(i == cntfc_pkg::MODE_CYC + 1, 1'b1);
    tick(200);
    compare(hits == 1, one_hit(16));
    compare(txd_pin, 1'b1);
    compare(tx_ready, 1'b1);
    compare(strobes > 0, 1'b1);
    hot = 1'b1;
    for (i = 0; i < 3; i++) push(1'b0);
    tx_valid = 1'b0;
    tick(10);
    compare(txd_pin, 1'b0);
    compare(rx_bit, 1'b1);
    other_dom = 1'b1;
    tick(3);
    compare(rx_bit, 1'b0);
    hot = 1'b0;
    other_dom = 1'b0;
    tick(20);
    // Long bits let a legal dominant run outlast the model's timeout
    bit_cycles = 24'h000028;
    for (i = 0; i < 11; i++) push(1'b0);
    tx_valid = 1'b0;
    tick(350);
    compare(txd_pin, 1'b0);
    compare(rx_bit, 1'b1);
    other_dom = 1'b1;
    tick(3);
    compare(rx_bit, 1'b0);
    other_dom = 1'b0;
    tick(200);
    compare(txd_pin, 1'b1);
    push(1'b0);
    tx_valid = 1'b0;
    tick(10);
    compare(rx_bit, 1'b0);
    tick(60);
    uv = 1'b1;
    other_dom = 1'b1;
    tick(3);
    compare(rx_bit, 1'b1);
    uv = 1'b0;
    tick(3);
    compare(rx_bit, 1'b0);
    other_dom = 1'b0;
    tick(5);
    bit_cycles = 24'h000000;
    push(1'b0);
    tx_valid = 1'b0;
    tick(int'(cntfc_pkg::BIT_CYC_RST) - 20);
    compare(txd_pin, 1'b0);
    tick(40);
    compare(txd_pin, 1'b1);
    bit_cycles = 24'h000008;
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      push(r[0]);
    end
    tx_valid = 1'b0;
    tick(400);
    compare(txd_pin, 1'b1);
    close_out;
  end
endmodule
`default_nettype wire
